// file: verilog/jarex_pkg.sv
package jarex_pkg;
  // First opcode byte, second byte of the two-byte access-rights load, and group ModRM reg values
  localparam logic [7:0] OP_CNTZ = 8'hE3;
  localparam logic [7:0] OP_SHORT = 8'hEB;
  localparam logic [7:0] OP_NEAR = 8'hE9;
  localparam logic [7:0] OP_FAR = 8'hEA;
  localparam logic [7:0] OP_GRP = 8'hFF;
  localparam logic [7:0] OP_FLGLD = 8'h9F;
  localparam logic [7:0] OP_RIGHTS = 8'h02;
  localparam logic [2:0] REG_NEAR_IND = 3'h4;
  localparam logic [2:0] REG_FAR_IND = 3'h5;
  // Instruction clocks, before the next-instruction byte count (a fault uses CYC_FAULT alone), plus counter width and ceiling
  localparam int CNT_W = 8;
  localparam logic [7:0] CYC_SHORT = 8'h07;
  localparam logic [7:0] CYC_CNTZ_TK = 8'h08;
  localparam logic [7:0] CYC_CNTZ_NT = 8'h04;
  localparam logic [7:0] CYC_IND_MEM = 8'h0B;
  localparam logic [7:0] CYC_FAR_RM = 8'h0B;
  localparam logic [7:0] CYC_FARI_RM = 8'h0F;
  localparam logic [7:0] CYC_FAR_PM = 8'h17;
  localparam logic [7:0] CYC_FARI_PM = 8'h1A;
  localparam logic [7:0] CYC_CGATE = 8'h26;
  localparam logic [7:0] CYC_CGATE_I = 8'h29;
  localparam logic [7:0] CYC_TSS = 8'hAF;
  localparam logic [7:0] CYC_TSS_I = 8'hB2;
  localparam logic [7:0] CYC_TGATE = 8'hB4;
  localparam logic [7:0] CYC_TGATE_I = 8'hB7;
  localparam logic [7:0] CYC_FLGLD = 8'h02;
  localparam logic [7:0] CYC_RIGHTS_REG = 8'h0E;
  localparam logic [7:0] CYC_RIGHTS_MEM = 8'h10;
  localparam logic [7:0] CYC_FAULT = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Fault vectors
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NP = 8'h0B;
  localparam logic [7:0] VEC_SS = 8'h0C;
  localparam logic [7:0] VEC_GP = 8'h0D;
  // Access rights byte layout, plus the zero flag bit of FLAGS
  localparam int AR_P = 7;
  localparam int AR_DPL_HI = 6;
  localparam int AR_DPL_LO = 5;
  localparam int AR_S = 4;
  localparam int AR_CODE = 3;
  localparam int AR_CONF = 2;
  localparam logic [4:0] TYPE_TSS_AVAIL = 5'h01;
  localparam logic [4:0] TYPE_CGATE = 5'h04;
  localparam logic [4:0] TYPE_TGATE = 5'h05;
  localparam int FLAG_ZF = 6;
  // Pending write bits
  localparam int P_IP = 0;
  localparam int P_CS = 1;
  localparam int P_FL = 2;
  localparam int P_AH = 3;
  localparam int P_DST = 4;
  localparam int P_FLT = 5;
  localparam int NPEND = 6;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DESC = 2'b01,
    ST_TASK = 2'b10,
    ST_WAIT = 2'b11
  } jarex_state_t;
  typedef enum logic [1:0] {
    PH_FAR = 2'b00,
    PH_GATE = 2'b01,
    PH_TSEL = 2'b10,
    PH_RIGHTS = 2'b11
  } jarex_phase_t;
endpackage

// file: verilog/jarex_cyc_cnt.sv
module jarex_cyc_cnt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [jarex_pkg::CNT_W-1:0] lim_i,
  output logic [jarex_pkg::CNT_W-1:0] cnt_o,
  output logic last_o
);
  import jarex_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } jarex_cnt_t;
  jarex_cnt_t r;
  jarex_cnt_t n;

  always_comb begin
    n = r;
    if (start_i) begin
      n.cnt = 8'h01;
    end else if (r.cnt != CNT_MAX) begin
      n.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign cnt_o = r.cnt;
  // High one cycle before the limit so the registered done lands on it
  assign last_o = ({1'b0, r.cnt} + 9'h001) >= {1'b0, lim_i};
endmodule // jarex_cyc_cnt

// file: verilog/jarex_desc_chk.sv
module jarex_desc_chk (
  input wire logic [7:0] ar_i,
  input wire logic [1:0] cpl_i,
  input wire logic [1:0] rpl_i,
  output logic present_o,
  output logic vis_o,
  output logic code_o,
  output logic conf_o,
  output logic code_ok_o,
  output logic cgate_o,
  output logic tgate_o,
  output logic tss_o
);
  import jarex_pkg::*;
  logic [1:0] descriptor_privilege_level;
  assign descriptor_privilege_level = ar_i[AR_DPL_HI:AR_DPL_LO];
  assign present_o = ar_i[AR_P];
  assign vis_o = (descriptor_privilege_level >= cpl_i) && (descriptor_privilege_level >= rpl_i);
  assign code_o = ar_i[AR_S] && ar_i[AR_CODE];
  assign conf_o = ar_i[AR_CONF];
  assign code_ok_o = conf_o ? (descriptor_privilege_level <= cpl_i) : (descriptor_privilege_level == cpl_i);
  assign cgate_o = ar_i[AR_S:0] == TYPE_CGATE;
  assign tgate_o = ar_i[AR_S:0] == TYPE_TGATE;
  assign tss_o = ar_i[AR_S:0] == TYPE_TSS_AVAIL;
endmodule // jarex_desc_chk

// file: verilog/jarex_exec.sv
module jarex_exec (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic START_I,
  input wire logic TWO_BYTE_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [2:0] MODRM_REG_I,
  input wire logic MODRM_IS_REG_I,
  input wire logic [15:0] DISP_I,
  input wire logic [15:0] PTR_OFF_I,
  input wire logic [15:0] PTR_SEL_I,
  input wire logic [15:0] OPER_WORD_I,
  input wire logic OPER_FAULT_I,
  input wire logic OPER_SS_I,
  input wire logic [15:0] NEXT_IP_I,
  input wire logic [3:0] NEXT_LEN_I,
  input wire logic PROT_MODE_I,
  input wire logic [1:0] CPL_I,
  input wire logic [15:0] CS_LIMIT_I,
  input wire logic [15:0] COUNT_REG_I,
  input wire logic [15:0] FLAGS_I,
  input wire logic [15:0] GDT_LIMIT_I,
  input wire logic [15:0] LDT_LIMIT_I,
  input wire logic DESC_ACK_I,
  input wire logic [7:0] DESC_AR_I,
  input wire logic [15:0] DESC_LIMIT_I,
  input wire logic [15:0] DESC_GSEL_I,
  input wire logic [15:0] DESC_GOFF_I,
  input wire logic TS_DONE_I,
  input wire logic [15:0] TS_FLAGS_I,
  input wire logic [15:0] TS_IP_I,
  input wire logic [15:0] TS_CS_I,
  input wire logic [15:0] TS_CS_LIMIT_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic IP_WE_O,
  output logic [15:0] IP_O,
  output logic CS_WE_O,
  output logic [15:0] CS_O,
  output logic [7:0] CACHE_AR_O,
  output logic [15:0] CACHE_LIMIT_O,
  output logic FLAGS_WE_O,
  output logic [15:0] FLAGS_O,
  output logic AH_WE_O,
  output logic [7:0] AH_O,
  output logic DEST_WE_O,
  output logic [15:0] DEST_O,
  output logic FAULT_O,
  output logic [7:0] FAULT_VEC_O,
  output logic [15:0] FAULT_CODE_O,
  output logic DESC_REQ_O,
  output logic [15:0] DESC_SEL_O,
  output logic TS_REQ_O,
  output logic [15:0] TS_SEL_O
);
  import jarex_pkg::*;

  typedef struct packed {
    jarex_state_t st;
    jarex_phase_t ph;
    logic ts;
    logic done;
    logic [15:0] sel;
    logic [15:0] goff;
    logic [15:0] ip;
    logic [15:0] cs;
    logic [15:0] clim;
    logic [15:0] flags;
    logic [15:0] dst;
    logic [15:0] fcode;
    logic [7:0] car;
    logic [7:0] ah;
    logic [7:0] fvec;
    logic [7:0] cost;
    logic [NPEND-1:0] pend;
    logic [NPEND-1:0] pulse;
  } jarex_regs_t;

  jarex_regs_t r;
  jarex_regs_t n;

  logic is_cntz, is_short, is_near, is_far, is_ind_n, is_ind_f, is_flgld, is_rights;
  logic is_ind, taken, take_new, cyc_last;
  logic [15:0] rel_tgt;
  logic [15:0] near_tgt;
  logic [7:0] cyc_lim;
  logic dc_present, dc_vis, dc_code, dc_conf, dc_code_ok, dc_cgate, dc_tgate, dc_tss;

  // Fault drops every pending write; the instruction has no effect
  function automatic jarex_regs_t fault(input jarex_regs_t s, input logic [7:0] v,
                                        input logic [15:0] c);
    fault = s;
    fault.pend = '0;
    fault.pend[P_FLT] = 1'b1;
    fault.fvec = v;
    fault.fcode = c;
    fault.st = ST_WAIT;
  endfunction

  function automatic logic idx_ok(input logic [15:0] s);
    idx_ok = s[2] ? ({s[15:3], 3'h7} <= LDT_LIMIT_I) : ({s[15:3], 3'h7} <= GDT_LIMIT_I);
  endfunction

  function automatic jarex_regs_t ldcode(input jarex_regs_t s, input logic [15:0] sl,
                                         input logic [15:0] off);
    ldcode = s;
    ldcode.cs = sl;
    ldcode.ip = off;
    ldcode.car = DESC_AR_I;
    ldcode.clim = DESC_LIMIT_I;
    ldcode.pend[P_IP] = 1'b1;
    ldcode.pend[P_CS] = 1'b1;
  endfunction

  assign is_cntz = !TWO_BYTE_I && OPCODE_I == OP_CNTZ;
  assign is_short = !TWO_BYTE_I && OPCODE_I == OP_SHORT;
  assign is_near = !TWO_BYTE_I && OPCODE_I == OP_NEAR;
  assign is_far = !TWO_BYTE_I && OPCODE_I == OP_FAR;
  assign is_ind_n = !TWO_BYTE_I && OPCODE_I == OP_GRP && MODRM_REG_I == REG_NEAR_IND;
  assign is_ind_f = !TWO_BYTE_I && OPCODE_I == OP_GRP && MODRM_REG_I == REG_FAR_IND;
  assign is_flgld = !TWO_BYTE_I && OPCODE_I == OP_FLGLD;
  assign is_rights = TWO_BYTE_I && OPCODE_I == OP_RIGHTS;
  assign is_ind = OPCODE_I == OP_GRP;
  assign taken = COUNT_REG_I == 16'h0000;
  // Carry out of bit 15 is dropped on purpose
  assign rel_tgt = NEXT_IP_I + (is_near ? DISP_I : {{8{DISP_I[7]}}, DISP_I[7:0]});
  assign near_tgt = is_ind_n ? OPER_WORD_I : rel_tgt;
  assign take_new = START_I && r.st == ST_IDLE;
  assign cyc_lim = r.pend[P_FLT] ? CYC_FAULT : r.cost + {4'h0, NEXT_LEN_I};

  jarex_desc_chk u_desc_chk (
    .ar_i(DESC_AR_I),
    .cpl_i(CPL_I),
    .rpl_i(r.sel[1:0]),
    .present_o(dc_present),
    .vis_o(dc_vis),
    .code_o(dc_code),
    .conf_o(dc_conf),
    .code_ok_o(dc_code_ok),
    .cgate_o(dc_cgate),
    .tgate_o(dc_tgate),
    .tss_o(dc_tss)
  );

  jarex_cyc_cnt u_cyc_cnt (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .start_i(take_new),
    .lim_i(cyc_lim),
    .cnt_o(),
    .last_o(cyc_last)
  );

  always_comb begin
    n = r;
    n.pulse = '0;
    n.done = 1'b0;
    case (r.st)
      ST_IDLE: begin
        if (START_I) begin
          n.pend = '0;
          n.ts = 1'b0;
          n.st = ST_WAIT;
          if (is_cntz || is_short || is_near || is_ind_n) begin
            n.ip = near_tgt;
            n.cost = is_cntz ? (taken ? CYC_CNTZ_TK : CYC_CNTZ_NT) :
                     (is_ind_n && !MODRM_IS_REG_I) ? CYC_IND_MEM : CYC_SHORT;
            n.pend[P_IP] = !is_cntz || taken;
            if (is_ind_n && !MODRM_IS_REG_I && OPER_FAULT_I) begin
              n = fault(n, OPER_SS_I ? VEC_SS : VEC_GP, 16'h0000);
            end else if (PROT_MODE_I && n.pend[P_IP] && near_tgt > CS_LIMIT_I) begin
              n = fault(n, VEC_GP, 16'h0000);
            end
          end else if (is_ind_f && MODRM_IS_REG_I) begin
            n = fault(n, VEC_UD, 16'h0000);
          end else if (is_ind_f && OPER_FAULT_I) begin
            n = fault(n, OPER_SS_I ? VEC_SS : VEC_GP, 16'h0000);
          end else if (is_far || is_ind_f) begin
            n.sel = PTR_SEL_I;
            n.goff = PTR_OFF_I;
            n.ph = PH_FAR;
            if (!PROT_MODE_I) begin
              n.ip = PTR_OFF_I;
              n.cs = PTR_SEL_I;
              n.pend[P_IP] = 1'b1;
              n.pend[P_CS] = 1'b1;
              n.cost = is_far ? CYC_FAR_RM : CYC_FARI_RM;
            end else if (PTR_SEL_I[15:2] == 14'h0000) begin
              n = fault(n, VEC_GP, 16'h0000);
            end else if (!idx_ok(PTR_SEL_I)) begin
              n = fault(n, VEC_GP, PTR_SEL_I);
            end else begin
              n.st = ST_DESC;
            end
          end else if (is_flgld) begin
            n.ah = FLAGS_I[7:0];
            n.pend[P_AH] = 1'b1;
            n.cost = CYC_FLGLD;
          end else if (is_rights && PROT_MODE_I) begin
            n.ph = PH_RIGHTS;
            n.cost = MODRM_IS_REG_I ? CYC_RIGHTS_REG : CYC_RIGHTS_MEM;
            if (!MODRM_IS_REG_I && OPER_FAULT_I) begin
              n = fault(n, OPER_SS_I ? VEC_SS : VEC_GP, 16'h0000);
            end else begin
              n.sel = OPER_WORD_I;
              n.flags = FLAGS_I;
              n.flags[FLAG_ZF] = 1'b0;
              n.pend[P_FL] = 1'b1;
              if (idx_ok(OPER_WORD_I)) begin
                n.st = ST_DESC;
              end
            end
          end else begin
            // Real-mode rights load and foreign opcodes
            n = fault(n, VEC_UD, 16'h0000);
          end
        end
      end
      ST_DESC: begin
        if (DESC_ACK_I) begin
          n.st = ST_WAIT;
          case (r.ph)
            PH_RIGHTS: begin
              if (dc_vis) begin
                n.dst = {DESC_AR_I, 8'h00};
                n.pend[P_DST] = 1'b1;
                n.flags[FLAG_ZF] = 1'b1;
              end
            end
            PH_FAR: begin
              n.cost = is_ind ? CYC_FARI_PM : CYC_FAR_PM;
              if (dc_code) begin
                if (!dc_code_ok || (!dc_conf && r.sel[1:0] > CPL_I)) begin
                  n = fault(n, VEC_GP, r.sel);
                end else if (!dc_present) begin
                  n = fault(n, VEC_NP, r.sel);
                end else if (r.goff > DESC_LIMIT_I) begin
                  n = fault(n, VEC_GP, 16'h0000);
                end else if (dc_conf) begin
                  n = ldcode(n, r.sel, r.goff);
                end else begin
                  n = ldcode(n, {r.sel[15:2], CPL_I}, r.goff);
                end
              end else if (dc_cgate) begin
                n.cost = is_ind ? CYC_CGATE_I : CYC_CGATE;
                if (!dc_vis) begin
                  n = fault(n, VEC_GP, r.sel);
                end else if (!dc_present) begin
                  n = fault(n, VEC_NP, r.sel);
                end else if (DESC_GSEL_I[15:2] == 14'h0000) begin
                  n = fault(n, VEC_GP, 16'h0000);
                end else if (!idx_ok(DESC_GSEL_I)) begin
                  n = fault(n, VEC_GP, DESC_GSEL_I);
                end else begin
                  // Pointer offset is dropped in favour of the gate's
                  n.sel = DESC_GSEL_I;
                  n.goff = DESC_GOFF_I;
                  n.ph = PH_GATE;
                  n.st = ST_DESC;
                end
              end else if (dc_tgate) begin
                n.cost = is_ind ? CYC_TGATE_I : CYC_TGATE;
                if (!dc_vis) begin
                  n = fault(n, VEC_GP, r.sel);
                end else if (!dc_present) begin
                  n = fault(n, VEC_NP, r.sel);
                end else if (DESC_GSEL_I[2] || !idx_ok(DESC_GSEL_I)) begin
                  n = fault(n, VEC_GP, DESC_GSEL_I);
                end else begin
                  n.sel = DESC_GSEL_I;
                  n.ph = PH_TSEL;
                  n.st = ST_DESC;
                end
              end else if (dc_tss) begin
                n.cost = is_ind ? CYC_TSS_I : CYC_TSS;
                if (!dc_vis) begin
                  n = fault(n, VEC_GP, r.sel);
                end else if (!dc_present) begin
                  n = fault(n, VEC_NP, r.sel);
                end else begin
                  n.st = ST_TASK;
                end
              end else begin
                n = fault(n, VEC_GP, r.sel);
              end
            end
            PH_GATE: begin
              if (!dc_code || !dc_code_ok) begin
                n = fault(n, VEC_GP, r.sel);
              end else if (!dc_present) begin
                n = fault(n, VEC_NP, r.sel);
              end else if (r.goff > DESC_LIMIT_I) begin
                n = fault(n, VEC_GP, 16'h0000);
              end else begin
                n = ldcode(n, {r.sel[15:2], CPL_I}, r.goff);
              end
            end
            default: begin
              if (!dc_tss) begin
                n = fault(n, VEC_GP, r.sel);
              end else if (!dc_present) begin
                n = fault(n, VEC_NP, r.sel);
              end else begin
                n.st = ST_TASK;
              end
            end
          endcase
        end
      end
      ST_TASK: begin
        // Save, busy marking and context load are done by the switch engine
        if (TS_DONE_I) begin
          n.st = ST_WAIT;
          n.ts = 1'b1;
          n.flags = TS_FLAGS_I;
          n.ip = TS_IP_I;
          n.cs = TS_CS_I;
          n.pend[P_IP] = 1'b1;
          n.pend[P_FL] = 1'b1;
          // Switch has already happened, so the fault lands in the new task
          n.pend[P_FLT] = TS_IP_I > TS_CS_LIMIT_I;
          n.fvec = VEC_GP;
          n.fcode = 16'h0000;
        end
      end
      ST_WAIT: begin
        if (cyc_last) begin
          n.pulse = r.pend;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= '0;
    end else if (CE_I) begin
      r <= n;
    end
  end

  assign BUSY_O = r.st != ST_IDLE;
  assign DONE_O = r.done;
  assign IP_WE_O = r.pulse[P_IP];
  assign IP_O = r.ip;
  assign CS_WE_O = r.pulse[P_CS];
  assign CS_O = r.cs;
  assign CACHE_AR_O = r.car;
  assign CACHE_LIMIT_O = r.clim;
  assign FLAGS_WE_O = r.pulse[P_FL];
  assign FLAGS_O = r.flags;
  assign AH_WE_O = r.pulse[P_AH];
  assign AH_O = r.ah;
  assign DEST_WE_O = r.pulse[P_DST];
  assign DEST_O = r.dst;
  assign FAULT_O = r.pulse[P_FLT];
  assign FAULT_VEC_O = r.fvec;
  assign FAULT_CODE_O = r.fcode;
  assign DESC_REQ_O = r.st == ST_DESC;
  assign DESC_SEL_O = r.sel;
  assign TS_REQ_O = r.st == ST_TASK;
  assign TS_SEL_O = r.sel;

  chk_count_zero: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    take_new && CE_I && is_cntz && !taken |=> !r.pend[P_IP]
  ) else $error("count jump taken with nonzero count");

  chk_cond_limit: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    take_new && CE_I && PROT_MODE_I && (is_short || is_near || (is_cntz && taken))
    && rel_tgt > CS_LIMIT_I
    |=> r.pend[P_FLT] && r.fvec == VEC_GP && r.fcode == 16'h0000 && !r.pend[P_IP]
  ) else $error("jump beyond limit did not fault with code zero");

  chk_short_clocks: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    take_new && CE_I && is_short && !PROT_MODE_I && NEXT_LEN_I == 4'h0
    |-> ##1 (!DONE_O)[*6] ##1 (DONE_O && IP_WE_O)
  ) else $error("short jump did not finish on its seventh clock");

  chk_flags_kept: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    FLAGS_WE_O |-> r.ts || r.ph == PH_RIGHTS
  ) else $error("flags written without task switch");

  chk_short_sext: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    take_new && CE_I && is_short
    |=> r.ip == $past(NEXT_IP_I) + {{8{$past(DISP_I[7])}}, $past(DISP_I[7:0])}
  ) else $error("short displacement not sign extended");

  chk_ud_regop: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    take_new && CE_I && is_ind_f && MODRM_IS_REG_I
    |=> r.pend == 6'h20 && r.fvec == VEC_UD
  ) else $error("register far indirect operand not rejected");

  chk_flags_copy: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    take_new && CE_I && is_flgld
    |=> r.ah == $past(FLAGS_I[7:0]) && r.pend == 6'h08
  ) else $error("flags low byte not copied alone");

  chk_rights_nofault: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    FAULT_O && r.ph == PH_RIGHTS |-> FAULT_CODE_O == 16'h0000 && FAULT_VEC_O != VEC_NP
  ) else $error("rights load faulted on its selector");
endmodule // jarex_exec

// file: dv/jarex_mem_model.sv
module jarex_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] lat_i,
  input wire logic desc_req_i,
  input wire logic [15:0] desc_sel_i,
  input wire logic ts_req_i,
  output logic desc_ack_o,
  output logic [7:0] desc_ar_o,
  output logic [15:0] desc_limit_o,
  output logic [15:0] desc_gsel_o,
  output logic [15:0] desc_goff_o,
  output logic ts_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Null, code, gate, conforming code, task gate, task segment, data, absent
  logic [7:0] ar_tab [8] = '{8'h00, 8'h9A, 8'hE4, 8'h9E, 8'hE5, 8'h81, 8'h92, 8'h1A};
  logic [3:0] dcnt, tcnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {dcnt, tcnt, desc_ack_o, ts_done_o} <= '0;
    end else begin
      desc_ack_o <= desc_req_i && !desc_ack_o && dcnt == lat_i;
      dcnt <= (desc_req_i && dcnt != lat_i) ? dcnt + 4'h1 : 4'h0;
      // Stands in for save, busy marks and context load; only raises done lat_i+1 clocks after the request
      ts_done_o <= ts_req_i && !ts_done_o && tcnt == lat_i;
      tcnt <= (ts_req_i && tcnt != lat_i) ? tcnt + 4'h1 : 4'h0;
    end
  end
  // Released words read back inverted, never as the last value
  assign desc_ar_o = desc_ack_o ? ar_tab[desc_sel_i[5:3]] : ~ar_tab[desc_sel_i[5:3]];
  assign desc_limit_o = desc_ack_o ? 16'hFFFF : 16'h0000;
  // Each gate names the entry after it
  assign desc_gsel_o = desc_ack_o ? desc_sel_i + 16'h0008 : ~desc_sel_i;
  assign desc_goff_o = desc_ack_o ? 16'h0040 : 16'hFFBF;
endmodule // jarex_mem_model

// file: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import jarex_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0, two = 1'b0, isreg = 1'b0;
  logic ofl = 1'b0, oss = 1'b0, pm = 1'b0, tsd, dack, dreq, tsreq, done, busy;
  logic ipwe, cswe, flwe, ahwe, dwe, flt;
  logic [7:0] op = 8'h00, ar, ah, vec, car;
  logic [1:0] current_privilege_level = 2'h0;
  logic [2:0] rg = 3'h0;
  logic [3:0] len = 4'h0, lat = 4'h1;
  logic [15:0] disp = '0, poff = '0, psel = '0, oper = '0, nip = '0, cnt = '0, fl = '0;
  logic [15:0] csl = 16'hFFFF, gdtl = 16'h003F, ldtl = '0, tsf = '0, tsip = '0;
  logic [15:0] tscs = 16'h0028, tslim = 16'hFFFF, rnd = 16'hCE18, ev;
  logic [15:0] dlim, gsel, goff, ip, cs, flo, dest, code, dsel, clim, tsel;
  logic [15:0] fsel [6] = '{16'h0008, 16'h0000, 16'h0040, 16'h0030, 16'h0038, 16'h0008};
  logic [7:0] fvec [6] = '{8'h00, VEC_GP, VEC_GP, VEC_GP, VEC_NP, VEC_GP};
  int error_cnt = 0, checked = 0, n, i;
  jarex_exec dut_u (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .START_I(start),
    .TWO_BYTE_I(two), .OPCODE_I(op), .MODRM_REG_I(rg), .MODRM_IS_REG_I(isreg),
    .DISP_I(disp), .PTR_OFF_I(poff), .PTR_SEL_I(psel), .OPER_WORD_I(oper),
    .OPER_FAULT_I(ofl), .OPER_SS_I(oss), .NEXT_IP_I(nip), .NEXT_LEN_I(len),
    .PROT_MODE_I(pm), .CPL_I(current_privilege_level), .CS_LIMIT_I(csl), .COUNT_REG_I(cnt), .FLAGS_I(fl),
    .GDT_LIMIT_I(gdtl), .LDT_LIMIT_I(ldtl), .DESC_ACK_I(dack), .DESC_AR_I(ar),
    .DESC_LIMIT_I(dlim), .DESC_GSEL_I(gsel), .DESC_GOFF_I(goff), .TS_DONE_I(tsd),
    .TS_FLAGS_I(tsf), .TS_IP_I(tsip), .TS_CS_I(tscs), .TS_CS_LIMIT_I(tslim),
    .BUSY_O(busy), .DONE_O(done), .IP_WE_O(ipwe), .IP_O(ip), .CS_WE_O(cswe), .CS_O(cs),
    .CACHE_AR_O(car), .CACHE_LIMIT_O(clim), .FLAGS_WE_O(flwe), .FLAGS_O(flo), .AH_WE_O(ahwe),
    .AH_O(ah), .DEST_WE_O(dwe), .DEST_O(dest), .FAULT_O(flt), .FAULT_VEC_O(vec),
    .FAULT_CODE_O(code), .DESC_REQ_O(dreq), .DESC_SEL_O(dsel), .TS_REQ_O(tsreq),
    .TS_SEL_O(tsel));
  jarex_mem_model mem_u (.clk_i(clk), .rst_i(rst), .lat_i(lat), .desc_req_i(dreq),
    .desc_sel_i(dsel), .ts_req_i(tsreq), .desc_ack_o(dack), .desc_ar_o(ar),
    .desc_limit_o(dlim), .desc_gsel_o(gsel), .desc_goff_o(goff), .ts_done_o(tsd));
  initial forever #2.5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input logic [47:0] a, input logic [47:0] e);
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("mismatch t=%0t act=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Inputs already settled; runs one instruction and counts cycles to done
  task automatic go(input logic [7:0] o, input logic [2:0] r, input logic rr, input logic m);
    @(posedge clk);
    op <= o;
    rg <= r;
    isreg <= rr;
    pm <= m;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // Cycle after the start edge counts as the first
    n = 1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      end_of_test();
    end
    cmp({done, busy}, 2'b10);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      disp <= rnd;
      nip <= {rnd[7:0], rnd[15:8]};
      len <= (i == 4) ? 4'h0 : rnd[3:0];
      go(i[0] ? OP_NEAR : OP_SHORT, 3'h0, 1'b0, i[1]);
      ev = nip + (i[0] ? disp : {{8{disp[7]}}, disp[7:0]});
      cmp({ipwe, cswe, flwe, ip}, {3'b100, ev});
      cmp(n, 7 + len);
    end
    for (i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      cnt <= (i == 1) ? rnd | 16'h0001 : 16'h0000;
      fl <= rnd;
      disp <= 16'h0010;
      nip <= 16'h0100;
      csl <= (i == 2) ? 16'h0100 : 16'hFFFF;
      go(OP_CNTZ, 3'h0, 1'b0, 1'b1);
      cmp({flt, ipwe & (ip !== 16'h0100)}, {i == 2, i == 0});
      if (i == 2) cmp({n[7:0], vec, code}, {8'h02, VEC_GP, 16'h0000});
    end
    @(posedge clk);
    csl <= 16'hFFFF;
    oper <= rnd;
    go(OP_GRP, REG_NEAR_IND, 1'b1, 1'b0);
    cmp({ipwe, cswe, ip, n[7:0]}, {2'b10, oper, 8'(7 + len)});
    for (i = 0; i < 2; i++) begin
      go(OP_GRP, REG_FAR_IND, 1'b1, i[0]);
      cmp({flt, ipwe, vec, code}, {2'b10, VEC_UD, 16'h0000});
    end
    @(posedge clk);
    poff <= rnd;
    psel <= ~rnd;
    go(OP_FAR, 3'h0, 1'b0, 1'b0);
    cmp({ip, cs, n[7:0]}, {poff, psel, 8'(11 + len)});
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      psel <= fsel[i];
      lat <= i[3:0];
      current_privilege_level <= (i == 5) ? 2'h3 : 2'h0;
      go(OP_FAR, 3'h0, 1'b0, 1'b1);
      if (i == 0) cmp({cswe, ip, cs, n[7:0]}, {1'b1, poff, psel, 8'(23 + len)});
      else cmp({flt, vec, code}, {1'b1, fvec[i], fsel[i]});
      if (i == 0) cmp({car, clim}, {8'h9A, 16'hFFFF});
    end
    @(posedge clk);
    psel <= 16'h0013;
    current_privilege_level <= 2'h0;
    lat <= 4'h6;
    go(OP_FAR, 3'h0, 1'b0, 1'b1);
    cmp({ipwe, cswe, ip, cs, n[7:0]}, {2'b11, 16'h0040, 16'h0018, 8'(38 + len)});
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      psel <= i ? 16'h0028 : 16'h0020;
      tsf <= rnd;
      tsip <= ~rnd;
      go(OP_FAR, 3'h0, 1'b0, 1'b1);
      cmp({flt, flwe, flo, ip}, {2'b01, tsf, tsip});
      cmp(n, (i ? 175 : 180) + len);
      cmp(tsel, 16'h0028);
    end
    @(posedge clk);
    fl <= rnd;
    go(OP_FLGLD, 3'h0, 1'b0, rnd[0]);
    cmp({ahwe, flwe, ah, n[7:0]}, {2'b10, fl[7:0], 8'(2 + len)});
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      two <= 1'b1;
      oper <= (i == 1) ? 16'h0043 : 16'h0008;
      ofl <= i == 2;
      oss <= i == 2;
      go(OP_RIGHTS, 3'h0, i != 2, 1'b1);
      if (i == 2) cmp({flt, vec, code}, {1'b1, VEC_SS, 16'h0000});
      else cmp({flt, flwe, flo[FLAG_ZF]}, {2'b01, i == 0});
      if (i == 0) cmp({dwe, dest, n[7:0]}, {1'b1, 16'h9A00, 8'(14 + len)});
    end
    end_of_test();
  end
endmodule // tb_top
